// *** pba_pkg.sv ***
`default_nettype none
package pba_pkg;
   localparam int AW = 18;
   localparam int DW = 16;
   localparam int NLVL = 4;
   // Transfer type line codes
   localparam logic [1:0] TT_WORD_READ = 2'h0;
   localparam logic [1:0] TT_WORD_WRITE = 2'h1;
   localparam logic [1:0] TT_BYTE_WRITE = 2'h3;
   localparam logic [DW-1:0] REG_RST = 16'h0000;
   localparam logic [NLVL-1:0] LVL_NONE = 4'h0;
   typedef enum logic [2:0] {
      ARB_IDLE = 3'h0, ARB_DMA_GNT = 3'h1, ARB_DMA_ACK = 3'h3,
      ARB_VEC_GNT = 3'h2, ARB_VEC_XFER = 3'h6,
      ARB_IO_SETUP = 3'h4, ARB_IO_STROBE = 3'h5, ARB_IO_END = 3'h7
   } pba_arb_t;
   typedef enum logic [2:0] {
      DEV_IDLE = 3'h0, DEV_DMA_REQ = 3'h1, DEV_DMA_ACK = 3'h3,
      DEV_DMA_XFER = 3'h2, DEV_DMA_END = 3'h6,
      DEV_IRQ_REQ = 3'h4, DEV_IRQ_ACK = 3'h5, DEV_IRQ_XFER = 3'h7
   } pba_dev_t;
   // Highest numbered asserted level wins
   function automatic logic [NLVL-1:0] pba_top_level(input logic [NLVL-1:0] req);
      logic [NLVL-1:0] r;
      r = LVL_NONE;
      for (int i = 0; i < NLVL; i++)
      begin
         if (req[i])
         begin
            r = LVL_NONE;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// *** pba_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pba_bus_if;
   import pba_pkg::*;
   // Adapter contributions
   logic            ad_init;
   logic            ad_dma_grant;
   logic [NLVL-1:0] ad_irq_grant_levels;
   logic            ad_bus_busy;
   logic            ad_master_strobe;
   logic            ad_slave_reply;
   logic [AW-1:0]   ad_addr;
   logic [1:0]      ad_xfer_type;
   logic [DW-1:0]   ad_data;
   logic            ad_data_oe;
   // Device contributions
   logic            dv_dma_request;
   logic [NLVL-1:0] dv_irq_request_levels;
   logic            dv_select_ack;
   logic            dv_bus_busy;
   logic            dv_master_strobe;
   logic            dv_slave_reply;
   logic            dv_vector_strobe;
   logic [AW-1:0]   dv_addr;
   logic [1:0]      dv_xfer_type;
   logic [DW-1:0]   dv_data;
   logic            dv_data_oe;
   // Resolved wired-or lines; address and type follow the bus owner
   logic            bus_busy_line;
   logic            master_strobe;
   logic            slave_reply;
   logic            vector_strobe;
   logic [AW-1:0]   addr;
   logic [1:0]      transfer_type_lines;
   logic [DW-1:0]   data;
   assign bus_busy_line = ad_bus_busy | dv_bus_busy;
   assign master_strobe = ad_master_strobe | dv_master_strobe;
   assign slave_reply = ad_slave_reply | dv_slave_reply;
   assign vector_strobe = dv_vector_strobe;
   assign addr = (ad_addr & {AW{ad_bus_busy}}) | (dv_addr & {AW{dv_bus_busy}});
   assign transfer_type_lines = (ad_xfer_type & {2{ad_bus_busy}})
                              | (dv_xfer_type & {2{dv_bus_busy}});
   assign data = (ad_data & {DW{ad_data_oe}}) | (dv_data & {DW{dv_data_oe}});
   modport adapter (
      output ad_init, ad_dma_grant, ad_irq_grant_levels, ad_bus_busy,
      output ad_master_strobe, ad_slave_reply, ad_addr, ad_xfer_type,
      output ad_data, ad_data_oe,
      input  dv_dma_request, dv_irq_request_levels, dv_select_ack,
      input  bus_busy_line, master_strobe, slave_reply, vector_strobe,
      input  addr, transfer_type_lines, data
   );
   modport device (
      output dv_dma_request, dv_irq_request_levels, dv_select_ack, dv_bus_busy,
      output dv_master_strobe, dv_slave_reply, dv_vector_strobe, dv_addr,
      output dv_xfer_type, dv_data, dv_data_oe,
      input  ad_init, ad_dma_grant, ad_irq_grant_levels,
      input  bus_busy_line, master_strobe, slave_reply, vector_strobe,
      input  addr, transfer_type_lines, data
   );
endinterface
`default_nettype wire

// *** pba_adapter.sv ***
// Notes on behaviour
// - Request levels serve interrupts only.
// - DMA masters never issue read-pause-write.
// - No vector transfer during DMA tenure.
// - DMA master holds bus nine cycles per transfer.
// - Transfer type lines encode read/write/byte-write.
// - Master strobe starts; slave reply answers.
// - Owner asserts bus busy while master.
// - Granted device asserts select acknowledge.
// - Initialize driven at reset and adapter reset.
// - Arbitrate only when enabled; one grant. No enable input here: the adapter arbitrates whenever in ARB_IDLE.
// - Pending DMA request gets DMA grant.
// - Non-requesting devices pass grant downstream.
// - Device waits bus idle, then takes it.
// - Lock on grant; unlock on acknowledge drop.
// - Host I/O owns idle bus directly.
// - Host I/O locks until slave reply.
// - Vector read last; busy-bus I/O ignored.
// - Grant level equals highest request level.
// - Selected device sends vector with strobe.
// - Vector transfer locks until adapter reply.
// - First requester blocks grant, acknowledges.
// - Adapter replies; strobe fall drops reply.
`timescale 1ns/100ps
`default_nettype none
module pba_adapter
   import pba_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk_in,
   input  wire logic            srst_in,
   input  wire logic            adapter_reset_in,
   // Host I/O command
   input  wire logic            io_start_in,
   input  wire logic            io_write_in,
   input  wire logic            io_byte_in,
   input  wire logic [AW-1:0]   io_addr_in,
   input  wire logic [DW-1:0]   io_wdata_in,
   output logic                 io_done_out,
   output logic [DW-1:0]        io_rdata_out,
   // Vector read command
   input  wire logic            vec_start_in,
   output logic                 vec_done_out,
   output logic [DW-1:0]        vec_data_out,
   output logic [NLVL-1:0]      processor_irq_request_out,
   // DMA memory side
   input  wire logic [DW-1:0]   dma_rdata_in,
   output logic                 dma_wr_out,
   output logic                 dma_byte_out,
   output logic [AW-1:0]        dma_addr_out,
   output logic [DW-1:0]        dma_wdata_out,
   // Peripheral bus
   pba_bus_if.adapter           bus
);
   pba_arb_t st_q, st_d;
   logic dreq_s, select_ack_s, busy_s, ms_s, sr_s, vs_s;
   logic [NLVL-1:0] ireq_s;
   logic [1:0] tt_s;
   logic [AW-1:0] addr_s;
   logic [DW-1:0] data_s;
   logic init_q;
   logic gnt_q, gnt_d, busy_q, busy_d, ms_q, ms_d, sr_q, sr_d, doe_q, doe_d;
   logic [NLVL-1:0] bg_q, bg_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [1:0] tt_q, tt_d;
   logic [DW-1:0] data_q, data_d;
   logic io_pend_q, io_pend_d, io_wr_q, io_wr_d, io_by_q, io_by_d;
   logic [AW-1:0] io_addr_q, io_addr_d;
   logic [DW-1:0] io_wd_q, io_wd_d;
   logic vec_pend_q, vec_pend_d;
   logic io_done_d, vec_done_d, dma_wr_d, dma_by_d;
   logic [DW-1:0] io_rd_q, io_rd_d, vec_q, vec_d, dma_wd_q, dma_wd_d;
   logic [AW-1:0] dma_a_q, dma_a_d;
   logic bus_idle, rst;

   // Synchronous clear from either reset source
   assign rst = srst_in | adapter_reset_in;
   assign bus_idle = !busy_s && !sr_s;

   always_ff @(posedge mclk_in)
   begin
      dreq_s <= bus.dv_dma_request;
      ireq_s <= bus.dv_irq_request_levels;
      select_ack_s <= bus.dv_select_ack;
      busy_s <= bus.bus_busy_line;
      ms_s <= bus.master_strobe;
      sr_s <= bus.slave_reply;
      vs_s <= bus.vector_strobe;
      tt_s <= bus.transfer_type_lines;
      addr_s <= bus.addr;
      data_s <= bus.data;
   end

   always_ff @(posedge mclk_in)
   begin
      init_q <= rst;
   end

   always_comb
   begin
      st_d = st_q;
      gnt_d = gnt_q;
      bg_d = bg_q;
      busy_d = busy_q;
      ms_d = ms_q;
      sr_d = sr_q;
      doe_d = doe_q;
      addr_d = addr_q;
      tt_d = tt_q;
      data_d = data_q;
      io_pend_d = io_pend_q | io_start_in;
      io_wr_d = io_wr_q;
      io_by_d = io_by_q;
      io_addr_d = io_addr_q;
      io_wd_d = io_wd_q;
      vec_pend_d = vec_pend_q | vec_start_in;
      io_done_d = 1'b0;
      vec_done_d = 1'b0;
      io_rd_d = io_rd_q;
      vec_d = vec_q;
      dma_wr_d = 1'b0;
      dma_by_d = dma_by_q_w();
      dma_a_d = dma_a_q;
      dma_wd_d = dma_wd_q;
      if (io_start_in && !io_pend_q)
      begin
         io_wr_d = io_write_in;
         io_by_d = io_byte_in;
         io_addr_d = io_addr_in;
         io_wd_d = io_wdata_in;
      end
      // slave for DMA masters; reply follows strobe
      if (st_q != ARB_VEC_XFER && !busy_q)
      begin
         if (ms_s && !sr_q)
         begin
            sr_d = 1'b1;
            if (tt_s == TT_WORD_READ)
            begin
               data_d = dma_rdata_in;
               doe_d = 1'b1;
            end
            else
            begin
               dma_wr_d = 1'b1;
               dma_by_d = (tt_s == TT_BYTE_WRITE);
               dma_a_d = addr_s;
               dma_wd_d = data_s;
            end
         end
         else if (!ms_s && sr_q)
         begin
            sr_d = 1'b0;
            doe_d = 1'b0;
         end
      end
      case (st_q)
         ARB_IDLE:
         begin
            if (dreq_s)
            begin
               gnt_d = 1'b1;
               st_d = ARB_DMA_GNT;
            end
            else if (io_pend_q && bus_idle)
            begin
               io_pend_d = io_start_in;
               busy_d = 1'b1;
               addr_d = io_addr_q;
               tt_d = !io_wr_q ? TT_WORD_READ : (io_by_q ? TT_BYTE_WRITE : TT_WORD_WRITE);
               data_d = io_wd_q;
               doe_d = io_wr_q;
               st_d = ARB_IO_SETUP;
            end
            else if (vec_pend_q && !(io_pend_q && bus_idle))
            begin
               vec_pend_d = vec_start_in;
               bg_d = pba_top_level(ireq_s);
               if (ireq_s == LVL_NONE)
               begin
                  vec_d = REG_RST;
                  vec_done_d = 1'b1;
               end
               else
               begin
                  st_d = ARB_VEC_GNT;
               end
            end
         end
         ARB_DMA_GNT:
         begin
            if (select_ack_s)
            begin
               gnt_d = 1'b0;
               st_d = ARB_DMA_ACK;
            end
         end
         ARB_DMA_ACK:
         begin
            if (!select_ack_s)
            begin
               st_d = ARB_IDLE;
            end
         end
         ARB_IO_SETUP:
         begin
            ms_d = 1'b1;
            st_d = ARB_IO_STROBE;
         end
         ARB_IO_STROBE:
         begin
            if (sr_s)
            begin
               ms_d = 1'b0;
               io_rd_d = data_s;
               st_d = ARB_IO_END;
            end
         end
         ARB_IO_END:
         begin
            if (!sr_s)
            begin
               busy_d = 1'b0;
               doe_d = 1'b0;
               io_done_d = 1'b1;
               st_d = ARB_IDLE;
            end
         end
         ARB_VEC_GNT:
         begin
            if (select_ack_s)
            begin
               bg_d = LVL_NONE;
               st_d = ARB_VEC_XFER;
            end
         end
         ARB_VEC_XFER:
         begin
            if (vs_s && !sr_q)
            begin
               sr_d = 1'b1;
               vec_d = data_s;
            end
            else if (!vs_s && sr_q)
            begin
               sr_d = 1'b0;
               vec_done_d = 1'b1;
               st_d = ARB_IDLE;
            end
         end
         default:
         begin
            st_d = ARB_IDLE;
         end
      endcase
   end

   function automatic logic dma_by_q_w();
      return dma_byte_out;
   endfunction

   always_ff @(posedge mclk_in)
   begin
      if (rst)
      begin
         st_q <= ARB_IDLE;
         gnt_q <= 1'b0;
         bg_q <= LVL_NONE;
         busy_q <= 1'b0;
         ms_q <= 1'b0;
         sr_q <= 1'b0;
         doe_q <= 1'b0;
         addr_q <= '0;
         tt_q <= TT_WORD_READ;
         data_q <= REG_RST;
         io_pend_q <= 1'b0;
         io_wr_q <= 1'b0;
         io_by_q <= 1'b0;
         io_addr_q <= '0;
         io_wd_q <= REG_RST;
         vec_pend_q <= 1'b0;
         io_done_out <= 1'b0;
         vec_done_out <= 1'b0;
         io_rd_q <= REG_RST;
         vec_q <= REG_RST;
         dma_wr_out <= 1'b0;
         dma_byte_out <= 1'b0;
         dma_a_q <= '0;
         dma_wd_q <= REG_RST;
      end
      else
      begin
         st_q <= st_d;
         gnt_q <= gnt_d;
         bg_q <= bg_d;
         busy_q <= busy_d;
         ms_q <= ms_d;
         sr_q <= sr_d;
         doe_q <= doe_d;
         addr_q <= addr_d;
         tt_q <= tt_d;
         data_q <= data_d;
         io_pend_q <= io_pend_d;
         io_wr_q <= io_wr_d;
         io_by_q <= io_by_d;
         io_addr_q <= io_addr_d;
         io_wd_q <= io_wd_d;
         vec_pend_q <= vec_pend_d;
         io_done_out <= io_done_d;
         vec_done_out <= vec_done_d;
         io_rd_q <= io_rd_d;
         vec_q <= vec_d;
         dma_wr_out <= dma_wr_d;
         dma_byte_out <= dma_by_d;
         dma_a_q <= dma_a_d;
         dma_wd_q <= dma_wd_d;
      end
   end

   assign io_rdata_out = io_rd_q;
   assign vec_data_out = vec_q;
   assign dma_addr_out = dma_a_q;
   assign dma_wdata_out = dma_wd_q;
   assign processor_irq_request_out = ireq_s;
   assign bus.ad_init = init_q;
   assign bus.ad_dma_grant = gnt_q;
   assign bus.ad_irq_grant_levels = bg_q;
   assign bus.ad_bus_busy = busy_q;
   assign bus.ad_master_strobe = ms_q;
   assign bus.ad_slave_reply = sr_q;
   assign bus.ad_addr = addr_q;
   assign bus.ad_xfer_type = tt_q;
   assign bus.ad_data = data_q;
   assign bus.ad_data_oe = doe_q;
endmodule
`default_nettype wire

// *** pba_device.sv ***
`timescale 1ns/100ps
`default_nettype none
module pba_device
   import pba_pkg::*;
#(
   // Arbitrary default register address
   parameter logic [AW-1:0] DEV_ADDR = 18'h2_0000
)
(
   // Clock and reset
   input  wire logic            mclk_in,
   input  wire logic            srst_in,
   // DMA job, taken only when idle
   input  wire logic            dma_start_in,
   input  wire logic            dma_write_in,
   input  wire logic            dma_byte_in,
   input  wire logic [AW-1:0]   dma_addr_in,
   input  wire logic [DW-1:0]   dma_wdata_in,
   output logic                 dma_done_out,
   output logic [DW-1:0]        dma_rdata_out,
   // Interrupt job, taken only when idle
   input  wire logic            irq_start_in,
   input  wire logic [1:0]      irq_level_in,
   input  wire logic [DW-1:0]   irq_vector_in,
   output logic                 irq_done_out,
   // Register and downstream chain
   output logic [DW-1:0]        reg_value_out,
   output logic                 dma_grant_chain_out,
   output logic [NLVL-1:0]      irq_grant_chain_out,
   // Peripheral bus
   pba_bus_if.device            bus
);
   pba_dev_t st_q, st_d;
   logic gnt_s, busy_s, ms_s, sr_s, init_s;
   logic [NLVL-1:0] bg_s;
   logic [1:0] tt_s;
   logic [AW-1:0] addr_s;
   logic [DW-1:0] data_s;
   logic dreq_q, dreq_d, select_ack_q, select_ack_d, busy_q, busy_d, ms_q, ms_d;
   logic vs_q, vs_d, sr_q, sr_d, doe_q, doe_d, dd_q, dd_d, id_q, id_d;
   logic gch_q, gch_d;
   logic [NLVL-1:0] ireq_q, ireq_d, ich_q, ich_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [1:0] tt_q, tt_d;
   logic [DW-1:0] data_q, data_d, rd_q, rd_d, reg_q, reg_d;

   always_ff @(posedge mclk_in)
   begin
      gnt_s <= bus.ad_dma_grant;
      bg_s <= bus.ad_irq_grant_levels;
      busy_s <= bus.bus_busy_line;
      ms_s <= bus.master_strobe;
      sr_s <= bus.slave_reply;
      init_s <= bus.ad_init;
      tt_s <= bus.transfer_type_lines;
      addr_s <= bus.addr;
      data_s <= bus.data;
   end

   always_comb
   begin
      st_d = st_q;
      dreq_d = dreq_q;
      ireq_d = ireq_q;
      select_ack_d = select_ack_q;
      busy_d = busy_q;
      ms_d = ms_q;
      vs_d = vs_q;
      sr_d = sr_q;
      doe_d = doe_q;
      addr_d = addr_q;
      tt_d = tt_q;
      data_d = data_q;
      rd_d = rd_q;
      reg_d = reg_q;
      dd_d = 1'b0;
      id_d = 1'b0;
      // pass grants unless requesting or holding one
      gch_d = gnt_s && !dreq_q && (st_q != DEV_DMA_ACK);
      ich_d = bg_s & ~ireq_q & {NLVL{st_q != DEV_IRQ_ACK}};
      // Register slave, only while not bus owner
      if (!busy_q)
      begin
         if (ms_s && !sr_q && addr_s == DEV_ADDR)
         begin
            sr_d = 1'b1;
            if (tt_s == TT_WORD_READ)
            begin
               data_d = reg_q;
               doe_d = 1'b1;
            end
            else if (tt_s == TT_BYTE_WRITE)
            begin
               reg_d[7:0] = data_s[7:0];
            end
            else
            begin
               reg_d = data_s;
            end
         end
         else if (sr_q && !ms_s)
         begin
            sr_d = 1'b0;
            doe_d = 1'b0;
         end
      end
      case (st_q)
         DEV_IDLE:
         begin
            if (dma_start_in)
            begin
               dreq_d = 1'b1;
               addr_d = addr_q_sel(dma_addr_in);
               tt_d = !dma_write_in ? TT_WORD_READ
                    : (dma_byte_in ? TT_BYTE_WRITE : TT_WORD_WRITE);
               data_d = dma_wdata_in;
               st_d = DEV_DMA_REQ;
            end
            else if (irq_start_in)
            begin
               ireq_d = LVL_NONE;
               ireq_d[irq_level_in] = 1'b1;
               data_d = irq_vector_in;
               st_d = DEV_IRQ_REQ;
            end
         end
         DEV_DMA_REQ:
         begin
            if (gnt_s)
            begin
               select_ack_d = 1'b1;
               dreq_d = 1'b0;
               st_d = DEV_DMA_ACK;
            end
         end
         DEV_DMA_ACK:
         begin
            if (!gnt_s && !busy_s && !sr_s)
            begin
               busy_d = 1'b1;
               doe_d = (tt_q != TT_WORD_READ);
               st_d = DEV_DMA_XFER;
            end
         end
         DEV_DMA_XFER:
         begin
            select_ack_d = 1'b0;
            ms_d = 1'b1;
            if (sr_s && ms_q)
            begin
               ms_d = 1'b0;
               rd_d = data_s;
               st_d = DEV_DMA_END;
            end
         end
         DEV_DMA_END:
         begin
            if (!sr_s)
            begin
               busy_d = 1'b0;
               doe_d = 1'b0;
               dd_d = 1'b1;
               st_d = DEV_IDLE;
            end
         end
         DEV_IRQ_REQ:
         begin
            if ((bg_s & ireq_q) != LVL_NONE)
            begin
               ireq_d = LVL_NONE;
               ich_d = LVL_NONE;
               select_ack_d = 1'b1;
               st_d = DEV_IRQ_ACK;
            end
         end
         // take bus, send vector with strobe
         DEV_IRQ_ACK:
         begin
            if (bg_s == LVL_NONE && !busy_s && !sr_s)
            begin
               busy_d = 1'b1;
               doe_d = 1'b1;
               vs_d = 1'b1;
               st_d = DEV_IRQ_XFER;
            end
         end
         DEV_IRQ_XFER:
         begin
            select_ack_d = 1'b0;
            if (sr_s && vs_q)
            begin
               busy_d = 1'b0;
               doe_d = 1'b0;
               vs_d = 1'b0;
               id_d = 1'b1;
               st_d = DEV_IDLE;
            end
         end
         default:
         begin
            st_d = DEV_IDLE;
         end
      endcase
   end

   function automatic logic [AW-1:0] addr_q_sel(input logic [AW-1:0] a);
      return a;
   endfunction

   // Initialize from the bus clears the device as a reset does
   always_ff @(posedge mclk_in)
   begin
      if (srst_in || init_s)
      begin
         st_q <= DEV_IDLE;
         dreq_q <= 1'b0;
         ireq_q <= LVL_NONE;
         select_ack_q <= 1'b0;
         busy_q <= 1'b0;
         ms_q <= 1'b0;
         vs_q <= 1'b0;
         sr_q <= 1'b0;
         doe_q <= 1'b0;
         addr_q <= '0;
         tt_q <= TT_WORD_READ;
         data_q <= REG_RST;
         rd_q <= REG_RST;
         reg_q <= REG_RST;
         dd_q <= 1'b0;
         id_q <= 1'b0;
         gch_q <= 1'b0;
         ich_q <= LVL_NONE;
      end
      else
      begin
         st_q <= st_d;
         dreq_q <= dreq_d;
         ireq_q <= ireq_d;
         select_ack_q <= select_ack_d;
         busy_q <= busy_d;
         ms_q <= ms_d;
         vs_q <= vs_d;
         sr_q <= sr_d;
         doe_q <= doe_d;
         addr_q <= addr_d;
         tt_q <= tt_d;
         data_q <= data_d;
         rd_q <= rd_d;
         reg_q <= reg_d;
         dd_q <= dd_d;
         id_q <= id_d;
         gch_q <= gch_d;
         ich_q <= ich_d;
      end
   end

   assign dma_done_out = dd_q;
   assign dma_rdata_out = rd_q;
   assign irq_done_out = id_q;
   assign reg_value_out = reg_q;
   assign dma_grant_chain_out = gch_q;
   assign irq_grant_chain_out = ich_q;
   assign bus.dv_dma_request = dreq_q;
   assign bus.dv_irq_request_levels = ireq_q;
   assign bus.dv_select_ack = select_ack_q;
   assign bus.dv_bus_busy = busy_q;
   assign bus.dv_master_strobe = ms_q;
   assign bus.dv_slave_reply = sr_q;
   assign bus.dv_vector_strobe = vs_q;
   assign bus.dv_addr = addr_q;
   assign bus.dv_xfer_type = tt_q;
   assign bus.dv_data = data_q;
   assign bus.dv_data_oe = doe_q;
endmodule
`default_nettype wire

// *** pba_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module pba_asserts
   import pba_pkg::*;
(
   // Clock and reset
   input wire logic            mclk_in,
   input wire logic            srst_in,
   // Bus lines
   input wire logic            ad_init,
   input wire logic            ad_dma_grant,
   input wire logic [NLVL-1:0] ad_irq_grant_levels,
   input wire logic [NLVL-1:0] dv_irq_request_levels,
   input wire logic            dv_select_ack,
   input wire logic            bus_busy_line,
   input wire logic            master_strobe,
   input wire logic            slave_reply,
   input wire logic            vector_strobe,
   input wire logic [1:0]      transfer_type_lines
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);
   sequence s_ack;
      dv_select_ack;
   endsequence
   sequence s_no_grant;
      !ad_dma_grant && ad_irq_grant_levels == LVL_NONE;
   endsequence
   one_grant_a: assert property (!(ad_dma_grant && |ad_irq_grant_levels)
      && $onehot0(ad_irq_grant_levels)) else $error("two grants at once");
   strobe_busy_a: assert property (master_strobe |-> bus_busy_line)
      else $error("strobe without bus busy");
   reply_cause_a: assert property ($rose(slave_reply) |-> master_strobe || vector_strobe)
      else $error("reply without strobe");
   vec_reply_drop_a: assert property ($fell(vector_strobe) |-> ##[1:4] !slave_reply)
      else $error("reply held after vector strobe");
   type_legal_a: assert property (bus_busy_line |-> transfer_type_lines != 2'h2)
      else $error("illegal transfer type");
   init_reset_a: assert property ($fell(srst_in) |-> ad_init)
      else $error("initialize missing at reset");
   grant_hold_a: assert property (ad_dma_grant && !dv_select_ack |=> ad_dma_grant)
      else $error("grant dropped before acknowledge");
   grant_release_a: assert property (s_ack |-> ##[1:4] s_no_grant)
      else $error("grant held after acknowledge");
   irq_level_a: assert property ($rose(|ad_irq_grant_levels) |->
      (ad_irq_grant_levels & $past(dv_irq_request_levels, 2)) != LVL_NONE)
      else $error("grant level not requested");
endmodule
`default_nettype wire

// *** test_peripheral_bus_priority_arbiter.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_peripheral_bus_priority_arbiter;
   import pba_pkg::*;
   logic            mclk_in = 1'b0;
   logic            srst_in = 1'b1;
   logic            io_start_in = 1'b0, io_write_in = 1'b0, io_byte_in = 1'b0;
   logic            vec_start_in = 1'b0, dma_start_in = 1'b0, dma_write_in = 1'b0;
   logic            irq_start_in = 1'b0, dma_byte_in = 1'b0, adapter_reset_in = 1'b0;
   logic [1:0]      irq_level_in = 2'h0;
   logic [AW-1:0]   io_addr_in = 18'h2_0000, dma_addr_in = 18'h0_0100;
   logic [DW-1:0]   io_wdata_in = 16'h0000, dma_wdata_in = 16'h0000;
   logic [DW-1:0]   dma_rdata_in = 16'h0000, irq_vector_in = 16'h0000;
   logic            io_done_out, vec_done_out, dma_wr_out, dma_done_out;
   logic            dma_byte_out, irq_done_out, dma_grant_chain_out;
   logic [NLVL-1:0] irq_grant_chain_out;
   int              irq_seen = 0, chain_seen = 0;
   logic [DW-1:0]   io_rdata_out, vec_data_out, dma_wdata_out, dma_rdata_out, reg_value_out;
   logic [AW-1:0]   dma_addr_out;
   logic [NLVL-1:0] processor_irq_request_out;
   int              bad_count = 0, compares = 0;
   pba_bus_if bus ();
   pba_adapter i_pba_adapter (.*);
   pba_device i_pba_device (.*);
   pba_asserts i_pba_asserts (.mclk_in, .srst_in, .ad_init(bus.ad_init),
      .ad_dma_grant(bus.ad_dma_grant), .ad_irq_grant_levels(bus.ad_irq_grant_levels),
      .dv_irq_request_levels(bus.dv_irq_request_levels), .dv_select_ack(bus.dv_select_ack),
      .bus_busy_line(bus.bus_busy_line), .master_strobe(bus.master_strobe),
      .slave_reply(bus.slave_reply), .vector_strobe(bus.vector_strobe),
      .transfer_type_lines(bus.transfer_type_lines));
   always #50 mclk_in = ~mclk_in;
   // Pulses and chain outputs counted mid-cycle, where they are settled
   always @(negedge mclk_in)
   begin
      if (irq_done_out === 1'b1)
         irq_seen++;
      if (dma_grant_chain_out !== 1'b0 || irq_grant_chain_out !== LVL_NONE)
         chain_seen++;
   end
   task tick;
      @(posedge mclk_in);
      #1;
   endtask
   task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for a done pulse
   task automatic wt(ref logic s);
      for (int n = 0; n < 200 && s !== 1'b1; n++)
         tick;
      chk({15'h0000, s}, 16'h0001);
   endtask
   task io(input logic w, input logic b, input logic [DW-1:0] d);
      io_write_in = w;
      io_byte_in = b;
      io_wdata_in = d;
      io_start_in = 1'b1;
      tick;
      io_start_in = 1'b0;
      wt(io_done_out);
   endtask
   task dm(input logic w, input logic b, input logic [DW-1:0] d);
      dma_write_in = w;
      dma_byte_in = b;
      dma_wdata_in = d;
      dma_start_in = 1'b1;
      tick;
      dma_start_in = 1'b0;
      if (w)
      begin
         wt(dma_wr_out);
         chk(dma_wdata_out, d);
         chk(dma_addr_out[DW-1:0], 16'h0100);
         chk({15'h0000, dma_byte_out}, {15'h0000, b});
      end
      wt(dma_done_out);
   endtask
   task vr;
      vec_start_in = 1'b1;
      tick;
      vec_start_in = 1'b0;
      wt(vec_done_out);
      repeat (6) tick;
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (8) tick;
      srst_in = 1'b0;
      repeat (4) tick;
      io(1'b1, 1'b0, 16'h1234);
      chk(reg_value_out, 16'h1234);
      io(1'b1, 1'b1, 16'habcd);
      chk(reg_value_out, 16'h12cd);
      io(1'b0, 1'b0, 16'h0000);
      chk(io_rdata_out, 16'h12cd);
      $display("host io test ended");
      dm(1'b1, 1'b0, 16'h5a5a);
      dma_rdata_in = 16'hc3c3;
      dm(1'b0, 1'b0, 16'h0000);
      chk(dma_rdata_out, 16'hc3c3);
      dm(1'b1, 1'b1, 16'h00a5);
      $display("dma test ended");
      vr;
      chk(vec_data_out, 16'h0000);
      // Every request level in turn
      for (int k = 0; k < 4; k++)
      begin
         irq_level_in = 2'(k);
         irq_vector_in = {10'h000, irq_level_in, 4'h0};
         irq_start_in = 1'b1;
         tick;
         irq_start_in = 1'b0;
         repeat (4) tick;
         chk({12'h000, processor_irq_request_out}, 16'h0001 << k);
         vr;
         chk(vec_data_out, {10'h000, irq_level_in, 4'h0});
      end
      chk(16'(irq_seen), 16'h0004);
      $display("vector test ended");
      chk(16'(chain_seen), 16'h0000);
      // Adapter reset reaches the device through initialize
      adapter_reset_in = 1'b1;
      repeat (2) tick;
      adapter_reset_in = 1'b0;
      repeat (4) tick;
      chk(reg_value_out, REG_RST);
      $display("reset test ended");
      final_report;
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      bad_count++;
      final_report;
   end
endmodule
`default_nettype wire
